// ### core/spd_ref_pkg.sv
// Types shared by the speed reference block
package spd_ref_pkg;

  typedef logic [7:0]  func_code_t;
  typedef logic [15:0] freq_t;

  typedef enum logic {
    SRC_TERMINALS,
    SRC_OPTION
  } ref_src_e;

endpackage : spd_ref_pkg

// ### core/spd_ref_regs.svh
// Register map, field positions, reset values and timing constants of the speed reference block
`ifndef SPD_REF_REGS_SVH
`define SPD_REF_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SPD_REG_TRIM_LEVEL   8'h00
`define SPD_REG_JOG_SPEED    8'h04
`define SPD_REG_SRC_CFG      8'h08
`define SPD_REG_MAX_FREQ     8'h0c
`define SPD_REG_STATUS       8'h10
`define SPD_REG_FREF_OUT     8'h14
`define SPD_REG_FUNC_BASE    8'h20
`define SPD_REG_FUNC_LAST    8'h44

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPD_SRC_SPEED_LSB    0
`define SPD_SRC_RUN_LSB      4
`define SPD_SRC_STOP_LSB     8
`define SPD_ST_CFG_ERR       0
`define SPD_ST_HELD          1
`define SPD_ST_OPTION        2
`define SPD_ST_JOG           3
`define SPD_ST_JOG_STOP      4

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define SPD_TRIM_DEFAULT     7'd10
`define SPD_TRIM_MAX         7'd100
`define SPD_PCT_FULL         23'd100
`define SPD_JOG_DEFAULT      16'd600
`define SPD_JOG_MAX          16'd12000
`define SPD_MAX_FREQ_DEFAULT 16'd6000
`define SPD_SRC_TERMINAL     4'd1

// ----------------------------------------------------------------
// Function selector codes
// ----------------------------------------------------------------
`define SPD_FN_SRC_SWITCH    8'h02
`define SPD_FN_UP            8'h10
`define SPD_FN_DOWN          8'h11
`define SPD_FN_JOG_FWD       8'h12
`define SPD_FN_JOG_REV       8'h13
`define SPD_FN_TRIM_INC      8'h1c
`define SPD_FN_TRIM_DEC      8'h1d
`define SPD_FN_SAMPLE_HOLD   8'h1e
`define SPD_FN_UNUSED        8'h0f

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPD_CLK_HZ           200000000
`define SPD_TICK_MS          1
`define SPD_HOLD_MS          100
`define SPD_JOG_STOP_MS      500

`endif

// ### core/speed_reference_input_commands.sv
// Contact-input handling for trim, sample/hold, source switching and jog
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "spd_ref_regs.svh"

// Operation
// - Selector code 1C makes a terminal trim increase, 1D trim decrease.
// - Trim level is 0 to 100 percent of max frequency, default 10, frozen while running.
// - Trim offset acts only when a terminal carries trim increase or decrease.
// - Increase adds offset, decrease subtracts, both equal leaves the reference unchanged.
// - Trim acts only when reference is above zero and comes from analog input.
// - A negative trimmed reference is clamped to zero.
// - Only one of trim increase or decrease assigned raises configuration error.
// - Code 1E captures the analog reference 100 ms after turn-on; run continues there.
// - Sample/hold on for under 100 ms captures nothing.
// - Sample/hold with ramp hold, up/down or trim raises configuration error.
// - Captured reference is volatile and cleared by reset.
// - Code 2 enables source switching, applied only while the drive is stopped.
// - Switch off selects terminals, on selects option board for reference and run.
// - Code 12 jogs forward, 13 reverse, at jog speed while the terminal is on.
// - Jog inputs start the drive without a separate run command.
// - Jog speed 0 to 120.00 Hz, default 6.00 Hz, changeable during run.
// - Jog frequency overrides every other reference source.
// - Both jog inputs on for 500 ms requests a stop by the stop method.
module speed_reference_input_commands
  import spd_ref_pkg::*;
#(
  parameter int   NUM_TERMS      = 10,
  parameter int   CYCLES_PER_MS  = (`SPD_CLK_HZ / 1000) * `SPD_TICK_MS,
  parameter logic [7:0] RAMP_HOLD_CODE = 8'h0a
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  // Avalon-MM slave
  input  wire logic [7:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  output var  logic [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  // Contact input pins
  input  wire logic [NUM_TERMS-1:0]  terminals_i,
  // Reference and command sources
  input  wire logic [15:0]           analog_ref_i,
  input  wire logic [15:0]           option_ref_i,
  input  wire logic                  option_run_i,
  input  wire logic                  option_rev_i,
  input  wire logic                  terminal_run_i,
  input  wire logic                  terminal_rev_i,
  input  wire logic                  drive_running_i,
  // Reference path and stop sequencer
  output var  logic [15:0]           freq_ref_o,
  output var  logic                  run_o,
  output var  logic                  reverse_o,
  output var  logic                  stop_req_o,
  output var  logic [3:0]            stop_method_o,
  output var  logic                  config_error_o,
  output var  logic                  ref_from_option_o
);

  localparam int HOLD_TICKS = `SPD_HOLD_MS / `SPD_TICK_MS;
  localparam int JOG_TICKS  = `SPD_JOG_STOP_MS / `SPD_TICK_MS;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [6:0]   trim_level_setting_r;
  logic [15:0]  jog_speed_setting_r;
  logic [3:0]   speed_ref_source_select_r;
  logic [3:0]   run_cmd_source_select_r;
  logic [3:0]   stop_method_select_r;
  logic [15:0]  max_freq_r;
  func_code_t   input_terminal_function_selectors_r [NUM_TERMS];
  logic         ack_r;
  logic [31:0]  rdata_nxt;
  logic         wr_en;
  logic         rd_en;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign wr_en             = avs_write_i & ack_r;
  assign rd_en             = avs_read_i & ~ack_r;

  // One wait cycle gives the read mux a full clock
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      trim_level_setting_r <= `SPD_TRIM_DEFAULT;
    end else if (wr_en && avs_address_i == `SPD_REG_TRIM_LEVEL && !drive_running_i
                 && avs_writedata_i[6:0] <= `SPD_TRIM_MAX && avs_writedata_i[31:7] == 25'h0) begin
      trim_level_setting_r <= avs_writedata_i[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      jog_speed_setting_r <= `SPD_JOG_DEFAULT;
    end else if (wr_en && avs_address_i == `SPD_REG_JOG_SPEED
                 && avs_writedata_i[15:0] <= `SPD_JOG_MAX && avs_writedata_i[31:16] == 16'h0) begin
      jog_speed_setting_r <= avs_writedata_i[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      speed_ref_source_select_r <= `SPD_SRC_TERMINAL;
      run_cmd_source_select_r   <= `SPD_SRC_TERMINAL;
      stop_method_select_r      <= 4'h0;
      max_freq_r                <= `SPD_MAX_FREQ_DEFAULT;
    end else if (wr_en && avs_address_i == `SPD_REG_SRC_CFG) begin
      speed_ref_source_select_r <= avs_writedata_i[`SPD_SRC_SPEED_LSB +: 4];
      run_cmd_source_select_r   <= avs_writedata_i[`SPD_SRC_RUN_LSB +: 4];
      stop_method_select_r      <= avs_writedata_i[`SPD_SRC_STOP_LSB +: 4];
    end else if (wr_en && avs_address_i == `SPD_REG_MAX_FREQ) begin
      max_freq_r                <= avs_writedata_i[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_TERMS; i++) begin
      if (!rst_b_i) begin
        input_terminal_function_selectors_r[i] <= `SPD_FN_UNUSED;
      end else if (wr_en && avs_address_i == 8'(`SPD_REG_FUNC_BASE + 4 * i)) begin
        input_terminal_function_selectors_r[i] <= avs_writedata_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Input synchroniser and millisecond tick
  // ----------------------------------------------------------------
  logic [NUM_TERMS-1:0] term_meta_r;
  logic [NUM_TERMS-1:0] multi_function_input_terminals_r;
  logic [31:0]          div_r;
  logic                 ms_tick_r;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      term_meta_r                      <= '0;
      multi_function_input_terminals_r <= '0;
    end else begin
      term_meta_r                      <= terminals_i;
      multi_function_input_terminals_r <= term_meta_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      div_r     <= 32'h0;
      ms_tick_r <= 1'b0;
    end else if (div_r == 32'(CYCLES_PER_MS - 1)) begin
      div_r     <= 32'h0;
      ms_tick_r <= 1'b1;
    end else begin
      div_r     <= div_r + 32'h1;
      ms_tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Function decode
  // ----------------------------------------------------------------
  logic has_inc, has_dec, has_sh, has_up, has_dn, has_ramp, has_sw;
  logic trim_inc_in, trim_dec_in, sh_in, sw_in, forward_jog_input, reverse_jog_input;

  always_comb begin
    has_inc = 1'b0; has_dec = 1'b0; has_sh = 1'b0; has_up = 1'b0;
    has_dn = 1'b0; has_ramp = 1'b0; has_sw = 1'b0;
    trim_inc_in = 1'b0; trim_dec_in = 1'b0; sh_in = 1'b0; sw_in = 1'b0;
    forward_jog_input = 1'b0; reverse_jog_input = 1'b0;
    for (int i = 0; i < NUM_TERMS; i++) begin
      if (input_terminal_function_selectors_r[i] == `SPD_FN_TRIM_INC) begin
        has_inc     = 1'b1;
        trim_inc_in = trim_inc_in | multi_function_input_terminals_r[i];
      end
      if (input_terminal_function_selectors_r[i] == `SPD_FN_TRIM_DEC) begin
        has_dec     = 1'b1;
        trim_dec_in = trim_dec_in | multi_function_input_terminals_r[i];
      end
      if (input_terminal_function_selectors_r[i] == `SPD_FN_SAMPLE_HOLD) begin
        has_sh = 1'b1;
        sh_in  = sh_in | multi_function_input_terminals_r[i];
      end
      if (input_terminal_function_selectors_r[i] == `SPD_FN_SRC_SWITCH) begin
        has_sw = 1'b1;
        sw_in  = sw_in | multi_function_input_terminals_r[i];
      end
      if (input_terminal_function_selectors_r[i] == `SPD_FN_JOG_FWD) begin
        forward_jog_input = forward_jog_input | multi_function_input_terminals_r[i];
      end
      if (input_terminal_function_selectors_r[i] == `SPD_FN_JOG_REV) begin
        reverse_jog_input = reverse_jog_input | multi_function_input_terminals_r[i];
      end
      if (input_terminal_function_selectors_r[i] == `SPD_FN_UP) begin
        has_up = 1'b1;
      end
      if (input_terminal_function_selectors_r[i] == `SPD_FN_DOWN) begin
        has_dn = 1'b1;
      end
      if (input_terminal_function_selectors_r[i] == RAMP_HOLD_CODE) begin
        has_ramp = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      config_error_o <= 1'b0;
    end else begin
      config_error_o <= (has_inc ^ has_dec) | (has_sh & (has_ramp | has_up | has_dn | has_inc | has_dec));
    end
  end

  // ----------------------------------------------------------------
  // Sample/hold
  // ----------------------------------------------------------------
  logic [9:0]  sh_cnt_r;
  logic [15:0] held_ref_r;
  logic        held_valid_r;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !sh_in || !has_sh) begin
      sh_cnt_r <= 10'h0;
    end else if (ms_tick_r && sh_cnt_r <= 10'(HOLD_TICKS)) begin
      sh_cnt_r <= sh_cnt_r + 10'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      held_ref_r   <= 16'h0;
      held_valid_r <= 1'b0;
    end else if (ms_tick_r && sh_in && has_sh && sh_cnt_r == 10'(HOLD_TICKS - 1)) begin
      held_ref_r   <= analog_ref_i;
      held_valid_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Source switch
  // ----------------------------------------------------------------
  ref_src_e src_r;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      src_r <= SRC_TERMINALS;
    end else if (!drive_running_i) begin
      src_r <= (has_sw && sw_in) ? SRC_OPTION : SRC_TERMINALS;
    end
  end

  // ----------------------------------------------------------------
  // Jog dual-input timer
  // ----------------------------------------------------------------
  logic [9:0] jog_cnt_r;
  logic       both_jog;

  assign both_jog = forward_jog_input & reverse_jog_input;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !both_jog) begin
      jog_cnt_r <= 10'h0;
    end else if (ms_tick_r && jog_cnt_r < 10'(JOG_TICKS)) begin
      jog_cnt_r <= jog_cnt_r + 10'h1;
    end
  end

  // ----------------------------------------------------------------
  // Reference path
  // ----------------------------------------------------------------
  logic [22:0] offset_full;
  logic [15:0] offset;
  logic [15:0] base_ref;
  logic [16:0] trimmed;
  logic        analog_src;
  logic        trim_ok;

  // Constant divide rounds the offset down at every level
  assign offset_full = (23'(max_freq_r) * 23'(trim_level_setting_r)) / `SPD_PCT_FULL;
  assign offset      = offset_full[15:0];
  assign analog_src  = speed_ref_source_select_r == `SPD_SRC_TERMINAL;
  assign base_ref    = (has_sh && held_valid_r) ? held_ref_r : analog_ref_i;
  assign trim_ok     = has_inc && has_dec && analog_src && base_ref != 16'h0;

  always_comb begin
    trimmed = {1'b0, base_ref};
    if (trim_ok && trim_inc_in && !trim_dec_in) begin
      trimmed = 17'(base_ref) + 17'(offset);
      if (trimmed[16]) begin
        trimmed = 17'h0ffff;
      end
    end else if (trim_ok && trim_dec_in && !trim_inc_in) begin
      trimmed = (offset > base_ref) ? 17'h0 : 17'(base_ref - offset);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      freq_ref_o        <= 16'h0;
      run_o             <= 1'b0;
      reverse_o         <= 1'b0;
      stop_req_o        <= 1'b0;
      stop_method_o     <= 4'h0;
      ref_from_option_o <= 1'b0;
    end else begin
      stop_method_o     <= stop_method_select_r;
      ref_from_option_o <= src_r == SRC_OPTION;
      stop_req_o        <= jog_cnt_r == 10'(JOG_TICKS);
      if (jog_cnt_r == 10'(JOG_TICKS)) begin
        run_o      <= 1'b0;
        freq_ref_o <= 16'h0;
      end else if (forward_jog_input || reverse_jog_input) begin
        freq_ref_o <= jog_speed_setting_r;
        run_o      <= 1'b1;
        if (!both_jog) begin
          reverse_o <= reverse_jog_input;
        end
      end else if (src_r == SRC_OPTION) begin
        freq_ref_o <= option_ref_i;
        run_o      <= option_run_i;
        reverse_o  <= option_rev_i;
      end else begin
        freq_ref_o <= trimmed[15:0];
        run_o      <= terminal_run_i && run_cmd_source_select_r == `SPD_SRC_TERMINAL;
        reverse_o  <= terminal_rev_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0;
    unique case (avs_address_i)
      `SPD_REG_TRIM_LEVEL: rdata_nxt = {25'h0, trim_level_setting_r};
      `SPD_REG_JOG_SPEED:  rdata_nxt = {16'h0, jog_speed_setting_r};
      `SPD_REG_SRC_CFG:    rdata_nxt = {20'h0, stop_method_select_r, run_cmd_source_select_r,
                                        speed_ref_source_select_r};
      `SPD_REG_MAX_FREQ:   rdata_nxt = {16'h0, max_freq_r};
      `SPD_REG_STATUS:     rdata_nxt = {27'h0, stop_req_o, forward_jog_input | reverse_jog_input,
                                        ref_from_option_o, held_valid_r, config_error_o};
      `SPD_REG_FREF_OUT:   rdata_nxt = {16'h0, freq_ref_o};
      default: begin
        for (int i = 0; i < NUM_TERMS; i++) begin
          if (avs_address_i == 8'(`SPD_REG_FUNC_BASE + 4 * i)) begin
            rdata_nxt = {24'h0, input_terminal_function_selectors_r[i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h0;
    end else if (rd_en) begin
      avs_readdata_o <= rdata_nxt;
    end
  end

endmodule : speed_reference_input_commands
`default_nettype wire

// ### tb/contact_switches.sv
// Model of the contact switch bank on the input pins
`timescale 1ns/1ps
`default_nettype none
module contact_switches #(
  parameter int NUM = 10
) (
  // Clock and throw request
  input  wire logic           clk_i,
  input  wire logic [NUM-1:0] want_i,
  input  wire logic [7:0]     lag_i,
  // Contact levels
  output var  logic [NUM-1:0] contacts_o
);
  logic [7:0]     age_r = 8'h00;
  logic [NUM-1:0] level_r = '0;
  // Single driver on the pins, level held in one register
  assign contacts_o = level_r;
  // Slow contacts settle lag cycles late, never bounce mid-level
  always @(posedge clk_i) begin
    if (want_i != level_r && age_r < lag_i) begin
      age_r <= age_r + 8'h01;
    end else begin
      age_r <= 8'h00;
      level_r <= want_i;
    end
  end
endmodule : contact_switches
`default_nettype wire

// ### tb/spd_ref_assertions.sv
// Port-level assertions for the speed reference block
`timescale 1ns/1ps
`default_nettype none
module spd_ref_checker (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Drive side
  input wire logic        drive_running_i,
  input wire logic [15:0] freq_ref_o,
  input wire logic        run_o,
  input wire logic        stop_req_o,
  input wire logic [3:0]  stop_method_o,
  input wire logic        config_error_o,
  input wire logic        ref_from_option_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic req;
  logic wr_acc;
  logic src_wr;
  assign req = avs_read_i | avs_write_i;
  assign wr_acc = avs_write_i & ~avs_waitrequest_o;
  assign src_wr = wr_acc & (avs_address_i == 8'h08);
  chk_wait_first: assert property (req && !$past(req) |-> avs_waitrequest_o)
    else $error("no wait state on new request");
  chk_wait_one: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait state");
  chk_wait_idle: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  chk_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 8'h18
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  chk_rdata_hold: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data moved without read");
  chk_src_stopped: assert property ($changed(ref_from_option_o) |-> !$past(drive_running_i, 2))
    else $error("source switched while running");
  chk_stop_zero: assert property (stop_req_o |-> freq_ref_o == 16'h0 && !run_o)
    else $error("stop request with drive still commanded");
  chk_meth_src: assert property ($changed(stop_method_o) |-> $past(src_wr) || $past(src_wr, 2))
    else $error("stop method changed without write");
  chk_meth_val: assert property (src_wr |-> ##2 stop_method_o == $past(avs_writedata_i[11:8], 2))
    else $error("stop method not taken from write");
  chk_cfg_cause: assert property ($changed(config_error_o)
    |-> $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3)) else $error("config error without write");
endmodule : spd_ref_checker
bind speed_reference_input_commands spd_ref_checker checker_inst (.clk_i, .rst_b_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .drive_running_i,
  .freq_ref_o, .run_o, .stop_req_o, .stop_method_o, .config_error_o, .ref_from_option_o);
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking testbench for the speed reference block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [9:0]  want = 10'h000;
  logic [7:0]  lag = 8'h00;
  logic [9:0]  terminals_i;
  logic [15:0] analog_ref_i = 16'h0;
  logic [15:0] option_ref_i = 16'h0;
  logic        option_run_i = 1'b0;
  logic        option_rev_i = 1'b0;
  logic        terminal_run_i = 1'b0;
  logic        terminal_rev_i = 1'b0;
  logic        drive_running_i = 1'b0;
  logic [15:0] freq_ref_o;
  logic        run_o, reverse_o, stop_req_o, config_error_o, ref_from_option_o;
  logic [3:0]  stop_method_o;
  logic [31:0] q;
  int          err_count = 0;
  int          checks_done = 0;

  always #2.5 clk_i = ~clk_i;

  // Short millisecond so hold and stop timers fit the run
  speed_reference_input_commands #(.CYCLES_PER_MS(10)) speed_reference_input_commands_inst (
    .clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .terminals_i, .analog_ref_i, .option_ref_i, .option_run_i, .option_rev_i,
    .terminal_run_i, .terminal_rev_i, .drive_running_i, .freq_ref_o, .run_o, .reverse_o,
    .stop_req_o, .stop_method_o, .config_error_o, .ref_from_option_o);
  contact_switches contact_switches_inst (.clk_i, .want_i(want), .lag_i(lag), .contacts_o(terminals_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // Request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask : rdc

  task automatic pins(input logic [9:0] w);
    @(posedge clk_i);
    want <= w;
    cyc(int'(lag) + 8);
  endtask : pins

  task automatic ana(input logic [15:0] v);
    @(posedge clk_i);
    analog_ref_i <= v;
    cyc(4);
  endtask : ana

  task automatic do_reset;
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
  endtask : do_reset

  task automatic t_regs;
    rdc(8'h00, 32'd10);
    rdc(8'h04, 32'd600);
    rdc(8'h08, 32'h11);
    rdc(8'h20, 32'h0f);
    wr(8'h18, 32'h5a);
    rdc(8'h18, 32'h0);
    @(posedge clk_i);
    drive_running_i <= 1'b1;
    wr(8'h00, 32'd50);
    rdc(8'h00, 32'd10);
    @(posedge clk_i);
    drive_running_i <= 1'b0;
    wr(8'h00, 32'd101);
    rdc(8'h00, 32'd10);
    wr(8'h00, 32'd100);
    rdc(8'h00, 32'd100);
    wr(8'h00, 32'd10);
    wr(8'h04, 32'd12001);
    rdc(8'h04, 32'd600);
    wr(8'h04, 32'd12000);
    rdc(8'h04, 32'd12000);
  endtask : t_regs

  // Offset is 10 percent of 6000
  task automatic t_trim;
    ana(16'd3000);
    wr(8'h20, 32'h1c);
    cyc(4);
    check(config_error_o, 1'b1);
    wr(8'h24, 32'h1d);
    cyc(4);
    check(config_error_o, 1'b0);
    pins(10'h001);
    check(freq_ref_o, 16'd3600);
    pins(10'h002);
    check(freq_ref_o, 16'd2400);
    pins(10'h003);
    check(freq_ref_o, 16'd3000);
    ana(16'd300);
    pins(10'h002);
    check(freq_ref_o, 16'd0);
    ana(16'd0);
    pins(10'h001);
    check(freq_ref_o, 16'd0);
    pins(10'h000);
    wr(8'h20, 32'h0f);
    wr(8'h24, 32'h0f);
  endtask : t_trim

  task automatic t_hold;
    wr(8'h28, 32'h1e);
    for (int i = 0; i < 3; i++) begin
      wr(8'h20, i == 2 ? 32'h0a : (i == 1 ? 32'h10 : 32'h1c));
      wr(8'h24, i == 2 ? 32'h0f : (i == 1 ? 32'h11 : 32'h1d));
      cyc(4);
      check(config_error_o, 1'b1);
    end
    wr(8'h20, 32'h0f);
    wr(8'h24, 32'h0f);
    cyc(4);
    check(config_error_o, 1'b0);
    ana(16'd1500);
    pins(10'h004);
    cyc(492);
    pins(10'h000);
    ana(16'd1700);
    check(freq_ref_o, 16'd1700);
    ana(16'd2000);
    pins(10'h004);
    cyc(900);
    ana(16'd2100);
    check(freq_ref_o, 16'd2100);
    cyc(300);
    ana(16'd2500);
    check(freq_ref_o, 16'd2100);
    pins(10'h000);
    check(freq_ref_o, 16'd2100);
    do_reset;
    wr(8'h28, 32'h1e);
    cyc(8);
    check(freq_ref_o, 16'd2500);
  endtask : t_hold

  task automatic t_src;
    wr(8'h2c, 32'h02);
    @(posedge clk_i);
    option_ref_i <= 16'd4321;
    option_run_i <= 1'b1;
    drive_running_i <= 1'b1;
    pins(10'h008);
    check(ref_from_option_o, 1'b0);
    @(posedge clk_i);
    drive_running_i <= 1'b0;
    cyc(8);
    check(ref_from_option_o, 1'b1);
    check({run_o, freq_ref_o}, {1'b1, 16'd4321});
    pins(10'h000);
    check({ref_from_option_o, run_o, freq_ref_o}, {2'b00, 16'd2500});
  endtask : t_src

  task automatic t_jog;
    lag <= 8'h03;
    wr(8'h30, 32'h12);
    wr(8'h34, 32'h13);
    wr(8'h04, 32'd1234);
    wr(8'h08, 32'h211);
    pins(10'h010);
    check({run_o, reverse_o, freq_ref_o}, {2'b10, 16'd1234});
    @(posedge clk_i);
    drive_running_i <= 1'b1;
    wr(8'h04, 32'd1500);
    cyc(8);
    check(freq_ref_o, 16'd1500);
    pins(10'h020);
    check({run_o, reverse_o, freq_ref_o}, {2'b11, 16'd1500});
    pins(10'h030);
    cyc(3000);
    pins(10'h010);
    pins(10'h030);
    cyc(3000);
    check(stop_req_o, 1'b0);
    cyc(2500);
    check({stop_req_o, stop_method_o, freq_ref_o}, {5'h12, 16'd0});
    pins(10'h000);
  endtask : t_jog

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_regs;
    t_trim;
    t_hold;
    t_src;
    t_jog;
    give_verdict;
  end

  // Whole sequence needs about 11000 cycles
  initial begin
    cyc(60000);
    err_count++;
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
